// ==== nmh_regs.svh ====
// frame layout constants, timing counts and register offsets for the node message handler
`ifndef NMH_REGS_SVH
`define NMH_REGS_SVH
// ****************************************
// frame codes and byte positions
// ****************************************
`define NMH_CODE_PROBE 8'h00
`define NMH_CODE_ALERT 8'h05
`define NMH_CODE_REMOVE 8'h11
`define NMH_CODE_RESPONSE 8'h0F
`define NMH_REV_PRE 8'h00
`define NMH_REV_FIRST 8'h02
`define NMH_REV_THIS 8'h10
`define NMH_FRAME_BYTES 32
`define NMH_B_CODE 0
`define NMH_B_PORT 1
`define NMH_B_TAG 2
`define NMH_B_ROUTE 4
`define NMH_B_ID 8
`define NMH_B_FLAGS 16
`define NMH_B_EVENT 16
`define NMH_B_CTRL 20
`define NMH_B_CHAN 21
`define NMH_B_PAYLOAD 23
`define NMH_B_RC 16
`define NMH_BIT_SKIP 7
`define NMH_BIT_ALIVE 6
// ****************************************
// return codes and alert kinds
// ****************************************
`define NMH_RC_OK 8'h00
`define NMH_RC_FAIL 8'h01
`define NMH_EVT_RECOVERY_EXIT 8'h01
`define NMH_EVT_NORMAL_MODE 8'h02
`define NMH_EVT_RECONFIGURE 8'h03
// ****************************************
// timing
// ****************************************
`define NMH_CLK_HZ 20000000
`define NMH_ALIVE_SEC 10
`define NMH_ALIVE_CYCLES (`NMH_ALIVE_SEC * `NMH_CLK_HZ)
// ****************************************
// register offsets of the host end
// ****************************************
`define NMH_REG_CMD 4'h0
`define NMH_REG_TAG 4'h1
`define NMH_REG_ROUTE 4'h2
`define NMH_REG_ID_LO 4'h3
`define NMH_REG_ID_HI 4'h4
`define NMH_REG_ARG 4'h5
`define NMH_REG_STATUS 4'h6
`define NMH_REG_IRQ_STAT 4'h7
`define NMH_REG_IRQ_CLR 4'h8
`define NMH_REG_IRQ_EN 4'h9
`define NMH_REG_RESULT 4'hA
`define NMH_REG_QUIESCE 4'hB
`define NMH_TABLE_DEPTH 4
`endif

// ==== nmh_pkg.sv ====
// types of the node message handler: frame kinds for the peer end, table entry states for the node end
package nmh_pkg;
  typedef logic [7:0] nmh_byte_t;
  typedef enum logic [1:0] {
    NMH_KIND_PROBE,
    NMH_KIND_ALERT,
    NMH_KIND_REMOVE
  } nmh_kind_t;
  typedef enum logic [1:0] {
    NMH_ENTRY_VACANT,
    NMH_ENTRY_RECORDED,
    NMH_ENTRY_ANNOUNCED
  } nmh_entry_t;
endpackage : nmh_pkg

// ==== nmh_link_if.sv ====
// byte-serial link carrying frames between a peer node and the storage node
`timescale 1ns/100ps
interface nmh_link_if;
  logic req_valid;
  logic req_last;
  logic [7:0] req_data;
  logic [1:0] req_port;
  logic rsp_valid;
  logic rsp_last;
  logic [7:0] rsp_data;
  logic [1:0] rsp_port;
  modport peer (
    output req_valid, req_last, req_data, req_port,
    input rsp_valid, rsp_last, rsp_data, rsp_port
  );
  modport node (
    input req_valid, req_last, req_data, req_port,
    output rsp_valid, rsp_last, rsp_data, rsp_port
  );
endinterface : nmh_link_if

// ==== nmh_node.sv ====
// storage node end: interprets probe, alert and remove-route frames
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "nmh_regs.svh"
module nmh_node #(
  parameter int unsigned ALIVE_CYCLES = `NMH_ALIVE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  nmh_link_if.node link,
  input wire logic i_quiesce_done,
  input wire logic i_announce,
  input wire logic [1:0] i_announce_slot,
  output logic o_quiesce_req,
  output logic [1:0] o_quiesce_port,
  output logic o_invalidate,
  output logic o_config_start,
  output logic o_supervisor_alive,
  output logic [7:0] o_peer_revision
);
  // ****************************************
  // receive frame buffer
  // ****************************************
  typedef enum logic [2:0] {S_RECV, S_EXEC, S_WAIT_Q, S_SEND} nmh_node_st_t;
  nmh_node_st_t state;
  logic [7:0] rx [0:`NMH_FRAME_BYTES-1];
  logic [7:0] tx [0:`NMH_FRAME_BYTES-1];
  logic [4:0] rx_cnt;
  logic [4:0] tx_cnt;
  logic [1:0] rx_port;
  // configuring-host table
  nmh_pkg::nmh_entry_t ent_state [0:`NMH_TABLE_DEPTH-1];
  logic [31:0] ent_route [0:`NMH_TABLE_DEPTH-1];
  logic [63:0] ent_ident [0:`NMH_TABLE_DEPTH-1];
  logic [1:0] ent_port [0:`NMH_TABLE_DEPTH-1];
  logic [31:0] alive_cnt;
  // gather big-endian field from the frame buffer
  function automatic logic [31:0] get32(input int unsigned base);
    get32 = {rx[base], rx[base+1], rx[base+2], rx[base+3]};
  endfunction : get32
  // ****************************************
  // decode of the held frame
  // ****************************************
  wire [7:0] f_code = rx[`NMH_B_CODE];
  logic [31:0] f_route;
  logic [63:0] f_ident;
  logic [31:0] f_entry_id;
  // a process, not net assignments: a net would not wake on the buffer bytes read inside get32
  always_comb begin
    f_route = get32(`NMH_B_ROUTE);
    f_ident = {get32(`NMH_B_ID), get32(`NMH_B_ID + 4)};
    f_entry_id = get32(`NMH_B_ROUTE + 4);
  end
  wire [1:0] f_port1 = rx[`NMH_B_FLAGS][1:0]; // upper bits reserved, ignored
  wire f_skip = rx[`NMH_B_FLAGS][`NMH_BIT_SKIP];
  wire f_alive = rx[`NMH_B_FLAGS][`NMH_BIT_ALIVE];
  wire [7:0] f_event = rx[`NMH_B_EVENT];
  wire is_probe = f_code == `NMH_CODE_PROBE;
  wire is_alert = f_code == `NMH_CODE_ALERT;
  wire is_remove = f_code == `NMH_CODE_REMOVE;
  // entry id is the table index; it must also sit on the named port and be announced
  wire [1:0] m_idx = f_entry_id[1:0];
  wire m_hit = (f_entry_id < `NMH_TABLE_DEPTH) && (ent_port[m_idx] == f_port1)
    && (ent_state[m_idx] == nmh_pkg::NMH_ENTRY_ANNOUNCED);
  // first vacant slot for probe registration
  logic [1:0] free_idx;
  logic free_ok;
  always_comb begin
    free_idx = 2'd0;
    free_ok = 1'b0;
    for (int i = `NMH_TABLE_DEPTH - 1; i >= 0; i--) begin
      if (ent_state[i] == nmh_pkg::NMH_ENTRY_VACANT) begin
        free_idx = i[1:0];
        free_ok = 1'b1;
      end
    end
  end
  wire need_quiesce = is_alert && (f_event == `NMH_EVT_RECOVERY_EXIT);
  wire rx_take = (state == S_RECV) && link.req_valid;
  // ****************************************
  // frame state machine
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= S_RECV;
      rx_cnt <= 5'd0;
      tx_cnt <= 5'd0;
      rx_port <= 2'd0;
    end else begin
      case (state)
        S_RECV: begin
          if (rx_take) begin
            rx_cnt <= rx_cnt + 5'd1;
            rx_port <= link.req_port;
            if (link.req_last) begin
              state <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          rx_cnt <= 5'd0;
          tx_cnt <= 5'd0;
          if (need_quiesce) begin
            state <= S_WAIT_Q;
          end else if (is_remove || is_alert) begin
            state <= S_SEND;
          end else begin
            state <= S_RECV; // probe reply frame is not handled here
          end
        end
        S_WAIT_Q: begin
          if (i_quiesce_done) begin
            state <= S_SEND;
          end
        end
        S_SEND: begin
          tx_cnt <= tx_cnt + 5'd1;
          if (tx_cnt == 5'(`NMH_FRAME_BYTES - 1)) begin
            state <= S_RECV;
          end
        end
        default: state <= S_RECV;
      endcase
    end
  end
  // frame buffer fill; missing bytes of short frames stay zero only if a reply frame was sent last
  always_ff @(posedge i_clk_sys) begin
    if (rx_take) begin
      rx[rx_cnt] <= link.req_data;
    end else if (state == S_SEND && tx_cnt == 5'(`NMH_FRAME_BYTES - 1)) begin
      for (int i = 0; i < `NMH_FRAME_BYTES; i++) begin
        rx[i] <= 8'h00;
      end
    end
  end
  // ****************************************
  // response frame build
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (state == S_EXEC) begin
      for (int i = 0; i < `NMH_FRAME_BYTES; i++) begin
        tx[i] <= 8'h00;
      end
      tx[`NMH_B_CODE] <= `NMH_CODE_RESPONSE;
      tx[`NMH_B_PORT] <= {6'd0, rx_port};
      tx[`NMH_B_TAG] <= rx[`NMH_B_TAG];
      tx[`NMH_B_TAG+1] <= rx[`NMH_B_TAG+1];
      for (int i = 0; i < 4; i++) begin
        tx[`NMH_B_ROUTE+i] <= rx[`NMH_B_ROUTE+i];
      end
      tx[`NMH_B_RC] <= (is_alert || m_hit) ? `NMH_RC_OK : `NMH_RC_FAIL;
    end
  end
  // ****************************************
  // table update
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `NMH_TABLE_DEPTH; i++) begin
        ent_state[i] <= nmh_pkg::NMH_ENTRY_VACANT;
        ent_route[i] <= 32'h0000_0000;
        ent_ident[i] <= 64'h0000_0000_0000_0000;
        ent_port[i] <= 2'd0;
      end
    end else if (state == S_EXEC && is_remove && m_hit) begin
      ent_state[m_idx] <= nmh_pkg::NMH_ENTRY_VACANT;
    end else if (state == S_EXEC && is_probe && !f_skip && free_ok) begin
      ent_state[free_idx] <= nmh_pkg::NMH_ENTRY_RECORDED;
      ent_route[free_idx] <= f_route;
      ent_ident[free_idx] <= f_ident;
      ent_port[free_idx] <= rx_port;
    end else if (i_announce && ent_state[i_announce_slot] == nmh_pkg::NMH_ENTRY_RECORDED) begin
      ent_state[i_announce_slot] <= nmh_pkg::NMH_ENTRY_ANNOUNCED;
    end
  end
  // ****************************************
  // supervisor-alive timer and side outputs
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      alive_cnt <= 32'd0;
      o_supervisor_alive <= 1'b0;
      o_peer_revision <= `NMH_REV_PRE;
      o_config_start <= 1'b0;
      o_invalidate <= 1'b0;
      o_quiesce_req <= 1'b0;
      o_quiesce_port <= 2'd0;
    end else begin
      o_config_start <= 1'b0;
      o_invalidate <= 1'b0;
      if (state == S_EXEC && is_probe && f_alive) begin
        alive_cnt <= ALIVE_CYCLES;
        o_supervisor_alive <= 1'b1;
      end else if (alive_cnt != 32'd0) begin
        alive_cnt <= alive_cnt - 32'd1;
        o_supervisor_alive <= alive_cnt != 32'd1;
      end
      if (state == S_EXEC && is_probe) begin
        o_peer_revision <= rx[`NMH_B_PORT];
      end
      if (state == S_EXEC && is_alert && f_event == `NMH_EVT_RECONFIGURE) begin
        o_config_start <= 1'b1;
      end
      if (state == S_EXEC && need_quiesce) begin
        o_quiesce_req <= 1'b1;
        o_quiesce_port <= rx[`NMH_B_PORT][1:0];
        o_invalidate <= 1'b1;
      end else if (state == S_WAIT_Q && i_quiesce_done) begin
        o_quiesce_req <= 1'b0;
      end
    end
  end
  // ****************************************
  // response transmit
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      link.rsp_valid <= 1'b0;
      link.rsp_last <= 1'b0;
      link.rsp_data <= 8'h00;
      link.rsp_port <= 2'd0;
    end else begin
      link.rsp_valid <= state == S_SEND;
      link.rsp_last <= state == S_SEND && tx_cnt == 5'(`NMH_FRAME_BYTES - 1);
      link.rsp_data <= (state == S_SEND) ? tx[tx_cnt] : 8'h00;
      link.rsp_port <= rx_port;
    end
  end
endmodule : nmh_node

// ==== nmh_peer.sv ====
// peer end: builds probe, alert and remove-route frames from software registers
`timescale 1ns/100ps
`include "nmh_regs.svh"
module nmh_peer (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  nmh_link_if.peer link,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq
);
  // ****************************************
  // software registers
  // ****************************************
  logic [31:0] cmd_arg;
  logic [15:0] tag;
  logic [31:0] route;
  logic [63:0] ident;
  logic [31:0] arg;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic [7:0] result_rc;
  logic [15:0] result_tag;
  logic busy;
  logic waiting;
  logic [4:0] tx_cnt;
  logic [4:0] rx_cnt;
  logic [7:0] frame [0:`NMH_FRAME_BYTES-1];
  logic [7:0] rsp_tag_hi;
  wire wr_cmd = i_wr && i_addr == `NMH_REG_CMD && !busy;
  wire [1:0] kind = i_wdata[1:0];
  wire [1:0] port = i_wdata[5:4];
  wire rsp_take = link.rsp_valid;
  wire rsp_done = rsp_take && link.rsp_last;
  wire tx_end = busy && !waiting && tx_cnt == 5'(`NMH_FRAME_BYTES - 1);
  // frame build at command write; ARG carries alert event/control, probe flags or the remove entry id
  always_ff @(posedge i_clk_sys) begin
    if (wr_cmd) begin
      for (int i = 0; i < `NMH_FRAME_BYTES; i++) begin
        frame[i] <= 8'h00;
      end
      frame[`NMH_B_TAG] <= tag[15:8];
      frame[`NMH_B_TAG+1] <= tag[7:0];
      for (int i = 0; i < 4; i++) begin
        frame[`NMH_B_ROUTE+i] <= route[31-8*i -: 8];
      end
      for (int i = 0; i < 8; i++) begin
        frame[`NMH_B_ID+i] <= ident[63-8*i -: 8];
      end
      case (nmh_pkg::nmh_kind_t'(kind))
        nmh_pkg::NMH_KIND_PROBE: begin
          frame[`NMH_B_CODE] <= `NMH_CODE_PROBE;
          frame[`NMH_B_PORT] <= `NMH_REV_THIS;
          frame[`NMH_B_FLAGS] <= {arg[7:3], 3'b000};
        end
        nmh_pkg::NMH_KIND_ALERT: begin
          frame[`NMH_B_CODE] <= `NMH_CODE_ALERT;
          frame[`NMH_B_PORT] <= {6'd0, port};
          frame[`NMH_B_EVENT] <= arg[7:0];
          frame[`NMH_B_CTRL] <= arg[15:8];
        end
        nmh_pkg::NMH_KIND_REMOVE: begin
          frame[`NMH_B_CODE] <= `NMH_CODE_REMOVE;
          for (int i = 0; i < 4; i++) begin
            frame[`NMH_B_ROUTE+4+i] <= arg[31-8*i -: 8];
          end
          frame[`NMH_B_FLAGS] <= {6'd0, port};
        end
        default: frame[`NMH_B_CODE] <= `NMH_CODE_PROBE;
      endcase
    end
  end
  // ****************************************
  // transmit and response tracking
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      busy <= 1'b0;
      waiting <= 1'b0;
      tx_cnt <= 5'd0;
      rx_cnt <= 5'd0;
      cmd_arg <= 32'h0000_0000;
      link.req_valid <= 1'b0;
      link.req_last <= 1'b0;
      link.req_data <= 8'h00;
      link.req_port <= 2'd0;
      result_rc <= 8'h00;
      result_tag <= 16'h0000;
      rsp_tag_hi <= 8'h00;
    end else begin
      link.req_valid <= busy && !waiting;
      link.req_last <= tx_end;
      link.req_data <= (busy && !waiting) ? frame[tx_cnt] : 8'h00;
      if (wr_cmd) begin
        busy <= 1'b1;
        tx_cnt <= 5'd0;
        cmd_arg <= i_wdata;
        link.req_port <= port;
      end else if (busy && !waiting) begin
        tx_cnt <= tx_cnt + 5'd1;
        if (tx_end) begin
          waiting <= 1'b1;
          rx_cnt <= 5'd0;
        end
      end
      // probes expect no response here; every other frame waits for its tag
      if (waiting && nmh_pkg::nmh_kind_t'(cmd_arg[1:0]) == nmh_pkg::NMH_KIND_PROBE) begin
        waiting <= 1'b0;
        busy <= 1'b0;
      end else if (waiting && rsp_take) begin
        rx_cnt <= rx_cnt + 5'd1;
        if (rx_cnt == 5'(`NMH_B_TAG)) begin
          rsp_tag_hi <= link.rsp_data;
        end
        if (rx_cnt == 5'(`NMH_B_TAG + 1)) begin
          result_tag <= {rsp_tag_hi, link.rsp_data};
        end
        if (rx_cnt == 5'(`NMH_B_RC)) begin
          result_rc <= link.rsp_data;
        end
        if (rsp_done) begin
          waiting <= 1'b0;
          busy <= result_tag != tag; // stay busy on a foreign tag, so the frame is sent again
        end
      end
    end
  end
  // ****************************************
  // interrupt: bit0 acknowledged, bit1 failure code
  // ****************************************
  wire ev_ack = waiting && rsp_done && result_tag == tag;
  wire ev_fail = ev_ack && result_rc != `NMH_RC_OK;
  wire wr_clr = i_wr && i_addr == `NMH_REG_IRQ_CLR;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat <= 2'b00;
      irq_en <= 2'b00;
      tag <= 16'h0000;
      route <= 32'h0000_0000;
      ident <= 64'h0000_0000_0000_0000;
      arg <= 32'h0000_0000;
      o_irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_clr ? i_wdata[1:0] : 2'b00)) | {ev_fail, ev_ack};
      o_irq <= |(irq_stat & irq_en);
      if (i_wr && i_addr == `NMH_REG_IRQ_EN) irq_en <= i_wdata[1:0];
      if (i_wr && i_addr == `NMH_REG_TAG) tag <= i_wdata[15:0]; // software keeps unique
      if (i_wr && i_addr == `NMH_REG_ROUTE) route <= i_wdata;
      if (i_wr && i_addr == `NMH_REG_ID_LO) ident[31:0] <= i_wdata;
      if (i_wr && i_addr == `NMH_REG_ID_HI) ident[63:32] <= i_wdata;
      if (i_wr && i_addr == `NMH_REG_ARG) arg <= i_wdata;
    end
  end
  // read data one cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `NMH_REG_TAG: o_rdata <= {16'h0000, tag};
        `NMH_REG_ROUTE: o_rdata <= route;
        `NMH_REG_ID_LO: o_rdata <= ident[31:0];
        `NMH_REG_ID_HI: o_rdata <= ident[63:32];
        `NMH_REG_ARG: o_rdata <= arg;
        `NMH_REG_STATUS: o_rdata <= {30'd0, waiting, busy};
        `NMH_REG_IRQ_STAT: o_rdata <= {30'd0, irq_stat};
        `NMH_REG_IRQ_EN: o_rdata <= {30'd0, irq_en};
        `NMH_REG_RESULT: o_rdata <= {8'h00, result_tag, result_rc};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule : nmh_peer

// ==== nmh_checker.sv ====
// link checker that watches both directions between the peer and node ends
`timescale 1ns/100ps
module nmh_checker (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic req_valid,
  input wire logic req_last,
  input wire logic [7:0] req_data,
  input wire logic [1:0] req_port,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_data,
  input wire logic [1:0] rsp_port
);
  logic [4:0] qn;
  logic [4:0] sn;
  logic [1:0] qp;
  logic [7:0] qb [0:31];
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // ****
  // byte positions in both directions
  // ****
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      qn <= 5'h0;
      sn <= 5'h0;
      qp <= 2'h0;
    end else begin
      if (req_valid) qn <= req_last ? 5'h0 : qn + 5'h1;
      if (req_valid) qp <= req_port;
      if (rsp_valid) sn <= rsp_last ? 5'h0 : sn + 5'h1;
    end
  end
  // request bytes kept so the reply can be held against them
  always_ff @(posedge i_clk_sys) begin
    if (req_valid) qb[qn] <= req_data;
  end
  a_req_framing: assert property (req_valid |-> req_last == (qn == 5'h1F))
    else $error("request frame not 32 bytes");
  a_probe_rev: assert property (req_valid && qn == 5'h01 && qb[0] == 8'h00 |-> req_data == 8'h10)
    else $error("probe revision byte wrong");
  a_probe_rsvd: assert property (req_valid && qn == 5'h10 && qb[0] == 8'h00 |-> req_data[2:0] == 3'h0)
    else $error("probe reserved bits not zero");
  a_probe_silent: assert property (req_valid && req_last && qb[0] == 8'h00 |=> !rsp_valid [*8])
    else $error("probe drew a reply");
  a_rsp_code: assert property (rsp_valid && sn == 5'h00 |-> rsp_data == 8'h0F && rsp_port == qp)
    else $error("reply code or port wrong");
  a_rsp_port: assert property (rsp_valid && sn == 5'h01 |-> rsp_data == {6'h00, qp})
    else $error("reply port byte wrong");
  a_rsp_echo: assert property (rsp_valid && sn >= 5'h02 && sn <= 5'h07 |-> rsp_data == qb[sn])
    else $error("reply tag or route not echoed");
  a_rsp_rc: assert property (rsp_valid && sn == 5'h10 |-> rsp_data inside {8'h00, 8'h01})
    else $error("reply return code illegal");
  a_rsp_whole: assert property (rsp_valid |-> rsp_last == (sn == 5'h1F))
    else $error("reply frame not 32 bytes");
  a_normal_prompt: assert property (req_valid && req_last && qb[0] == 8'h05 && qb[16] == 8'h02
    |-> ##[1:4] rsp_valid)
    else $error("normal mode alert reply late");
  a_remove_reply: assert property (req_valid && req_last && qb[0] == 8'h11 |-> ##[1:4] rsp_valid)
    else $error("remove request not answered");
endmodule : nmh_checker

// ==== nmh_tb_top.sv ====
// bench joining the peer and node ends over one link
`timescale 1ns/100ps
`include "nmh_regs.svh"
module nmh_tb_top;
  localparam int ALIVE = 60;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_quiesce_done = 1'b0;
  logic i_announce = 1'b0;
  logic [1:0] i_announce_slot = 2'h0;
  logic [31:0] o_rdata;
  logic o_irq, o_quiesce_req, o_invalidate, o_config_start, o_supervisor_alive;
  logic [1:0] o_quiesce_port;
  logic [7:0] o_peer_revision;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 42095;
  int n_cfg = 0;
  int n_inv = 0;
  int rn = 0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_rd [$];
  logic [25:0] exp_rsp [$];
  logic [7:0] rb [0:31];
  logic [15:0] tag;
  logic [31:0] r;
  logic [31:0] rexp;
  logic [25:0] note;
  nmh_link_if link ();
  nmh_peer u_nmh_peer (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(link), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
  nmh_node #(.ALIVE_CYCLES(ALIVE)) u_nmh_node (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .link(link), .i_quiesce_done(i_quiesce_done), .i_announce(i_announce),
    .i_announce_slot(i_announce_slot), .o_quiesce_req(o_quiesce_req),
    .o_quiesce_port(o_quiesce_port), .o_invalidate(o_invalidate),
    .o_config_start(o_config_start), .o_supervisor_alive(o_supervisor_alive),
    .o_peer_revision(o_peer_revision));
  nmh_checker u_nmh_checker (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .req_valid(link.req_valid), .req_last(link.req_last), .req_data(link.req_data),
    .req_port(link.req_port), .rsp_valid(link.rsp_valid), .rsp_last(link.rsp_last),
    .rsp_data(link.rsp_data), .rsp_port(link.rsp_port));
  // 20 MHz system clock
  always #25 i_clk_sys = ~i_clk_sys;
  // ****
  // shared tasks
  // ****
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic report_and_stop(input bit hang);
    if (hang) n_mismatch++;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask : rd
  // bounded wait for the end of a request (w=0) or reply (w=1) frame
  task automatic wait_link(input bit w);
    for (int i = 0; i < 300; i++) begin
      @(posedge i_clk_sys);
      if (w ? (link.rsp_valid && link.rsp_last) : (link.req_valid && link.req_last)) return;
    end
    report_and_stop(1'b1);
  endtask : wait_link
  // one frame through the peer registers; the reply is noted before launch
  task automatic send(input logic [1:0] k, input logic [1:0] p, input logic [7:0] arg,
    input logic [7:0] rc, input bit hold);
    tag = tag + 16'h0001;
    wr(`NMH_REG_TAG, {16'h0000, tag});
    wr(`NMH_REG_ROUTE, $random(seed));
    wr(`NMH_REG_ID_LO, $random(seed));
    wr(`NMH_REG_ID_HI, $random(seed));
    wr(`NMH_REG_ARG, {24'h00_0000, arg});
    if (k != 2'h0) exp_rsp.push_back({p, tag, rc});
    wr(`NMH_REG_CMD, {26'h000_0000, p, 2'h0, k});
    wait_link(1'b0);
    if (k != 2'h0 && !hold) wait_link(1'b1);
  endtask : send
  // monitor: read data and reply frames are checked against the oldest note
  always @(posedge i_clk_sys) begin
    rd_pend <= i_rd;
    if (rd_pend) cmp(o_rdata, exp_rd.pop_front());
    if (o_config_start === 1'b1) n_cfg++;
    if (o_invalidate === 1'b1) n_inv++;
    if (link.rsp_valid === 1'b1) begin
      rb[rn] = link.rsp_data;
      rn = link.rsp_last ? 0 : rn + 1;
      if (link.rsp_last) begin
        // pop first: operand order inside one concatenation is not fixed
        note = exp_rsp.pop_front();
        rexp = {4'h0, note[25:24], note};
        cmp({4'h0, link.rsp_port, rb[1][1:0], rb[2], rb[3], rb[16]}, rexp);
      end
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    tag = 16'($random(seed));
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rd(4'hF, 32'h0000_0000);
    wr(`NMH_REG_IRQ_EN, 32'h0000_0003);
    send(2'h2, 2'h1, 8'h00, 8'h01, 1'b0);
    rd(`NMH_REG_IRQ_STAT, 32'h0000_0003);
    cmp(32'(o_irq), 32'h0000_0001);
    wr(`NMH_REG_IRQ_CLR, 32'h0000_0003);
    rd(`NMH_REG_IRQ_STAT, 32'h0000_0000);
    cmp(32'(o_irq), 32'h0000_0000);
    wr(`NMH_REG_IRQ_EN, 32'h0000_0000);
    r = $random(seed);
    send(2'h0, 2'h1, {2'h1, r[2:0], 3'h0}, 8'h00, 1'b0);
    repeat (3) @(posedge i_clk_sys);
    cmp(32'(o_supervisor_alive), 32'h0000_0001);
    cmp(32'(o_peer_revision), 32'h0000_0010);
    repeat (30) @(posedge i_clk_sys);
    send(2'h0, 2'h2, {2'h3, r[5:3], 3'h0}, 8'h00, 1'b0);
    repeat (3) @(posedge i_clk_sys);
    cmp(32'(o_supervisor_alive), 32'h0000_0001);
    repeat (ALIVE + 10) @(posedge i_clk_sys);
    cmp(32'(o_supervisor_alive), 32'h0000_0000);
    send(2'h2, 2'h1, 8'h00, 8'h01, 1'b0);
    for (int s = 0; s < 2; s++) begin
      @(posedge i_clk_sys);
      i_announce <= 1'b1;
      i_announce_slot <= 2'(s);
    end
    @(posedge i_clk_sys);
    i_announce <= 1'b0;
    send(2'h2, 2'h2, 8'h01, 8'h01, 1'b0);
    send(2'h2, 2'h2, 8'h00, 8'h01, 1'b0);
    send(2'h2, 2'h1, 8'h00, 8'h00, 1'b0);
    send(2'h2, 2'h1, 8'h00, 8'h01, 1'b0);
    rd(`NMH_REG_IRQ_STAT, 32'h0000_0003);
    cmp(32'(o_irq), 32'h0000_0000);
    wr(`NMH_REG_IRQ_EN, 32'h0000_0001);
    // enable lands at one edge, the registered interrupt follows at the next
    repeat (2) @(posedge i_clk_sys);
    cmp(32'(o_irq), 32'h0000_0001);
    send(2'h1, 2'h3, `NMH_EVT_NORMAL_MODE, 8'h00, 1'b0);
    send(2'h1, 2'h2, `NMH_EVT_RECONFIGURE, 8'h00, 1'b0);
    repeat (2) @(posedge i_clk_sys);
    cmp(32'(n_cfg), 32'h0000_0001);
    send(2'h1, 2'h2, `NMH_EVT_RECOVERY_EXIT, 8'h00, 1'b1);
    repeat (10) @(posedge i_clk_sys);
    cmp(32'({o_quiesce_req, o_quiesce_port}), 32'h0000_0006);
    cmp(32'(link.rsp_valid), 32'h0000_0000);
    i_quiesce_done <= 1'b1;
    wait_link(1'b1);
    i_quiesce_done <= 1'b0;
    cmp(32'(n_inv), 32'h0000_0001);
    repeat (5) @(posedge i_clk_sys);
    cmp(32'(exp_rsp.size()), 32'h0000_0000);
    report_and_stop(1'b0);
  end
endmodule : nmh_tb_top
